// >>> smise_pkg.sv
// Purpose: Shared constants and types of the management interrupt source enable bank
// Assumes: 32-bit AXI4-Lite register bus, byte address equals register index times four
// Notes:   All registers are eight bits wide and sit in the low byte of a word
package smise_pkg;

  // ************************************************************
  // Bus geometry
  // ************************************************************
  localparam int AXI_ADDR_W = 8;
  localparam int AXI_DATA_W = 32;
  localparam int BANK_W     = 8;
  localparam int NUM_BANKS  = 3;
  localparam int EVENT_W    = NUM_BANKS * BANK_W;

  // ************************************************************
  // Register indices and byte addresses
  // ************************************************************
  localparam logic [7:0] IDX_STS_THREE = 8'h12;
  localparam logic [7:0] IDX_STS_FOUR  = 8'h13;
  localparam logic [7:0] IDX_STS_FIVE  = 8'h14;
  localparam logic [7:0] IDX_ROUTE     = 8'h17;
  localparam logic [7:0] IDX_EN_THREE  = 8'h18;
  localparam logic [7:0] IDX_EN_FOUR   = 8'h19;
  localparam logic [7:0] IDX_EN_FIVE   = 8'h1A;

  localparam logic [AXI_ADDR_W-1:0] ADDR_STS_THREE = 8'(IDX_STS_THREE * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_STS_FOUR  = 8'(IDX_STS_FOUR * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_STS_FIVE  = 8'(IDX_STS_FIVE * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_ROUTE     = 8'(IDX_ROUTE * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_EN_THREE  = 8'(IDX_EN_THREE * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_EN_FOUR   = 8'(IDX_EN_FOUR * 4);
  localparam logic [AXI_ADDR_W-1:0] ADDR_EN_FIVE   = 8'(IDX_EN_FIVE * 4);

  // ************************************************************
  // Field positions and reset values
  // ************************************************************
  localparam int ROUTE_SERIAL_BIT = 6;
  localparam int ROUTE_PIN_BIT    = 7;
  localparam int FAN_SENSE_BIT    = 5;

  localparam logic [BANK_W-1:0] EN_RESET    = 8'h00;
  localparam logic [BANK_W-1:0] STS_RESET   = 8'h00;
  localparam logic              ROUTE_RESET = 1'b0;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // ************************************************************
  // Register select codes
  // ************************************************************
  localparam logic [2:0] SEL_STS_THREE = 3'h0;
  localparam logic [2:0] SEL_STS_FOUR  = 3'h1;
  localparam logic [2:0] SEL_STS_FIVE  = 3'h2;
  localparam logic [2:0] SEL_EN_THREE  = 3'h3;
  localparam logic [2:0] SEL_EN_FOUR   = 3'h4;
  localparam logic [2:0] SEL_EN_FIVE   = 3'h5;
  localparam logic [2:0] SEL_ROUTE     = 3'h6;
  localparam logic [2:0] SEL_NONE      = 3'h7;

  // ************************************************************
  // Types
  // ************************************************************
  typedef enum logic [1:0] {
    WR_COLLECT = 2'b01,
    WR_RESP    = 2'b10
  } smise_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'b01,
    RD_RESP = 2'b10
  } smise_rd_state_t;

  typedef struct packed {
    smise_wr_state_t              wrState;
    smise_rd_state_t              rdState;
    logic                         awHeld;
    logic                         wHeld;
    logic [AXI_ADDR_W-1:0]        awAddr;
    logic [BANK_W-1:0]            wByte;
    logic                         wLane0;
    logic [1:0]                   bresp;
    logic [AXI_DATA_W-1:0]        rdata;
    logic [1:0]                   rresp;
    logic [NUM_BANKS-1:0][BANK_W-1:0] sts;
    logic [NUM_BANKS-1:0][BANK_W-1:0] en;
    logic                         routePin;
    logic                         routeSerial;
    logic                         groupActive;
    logic                         pinActive;
    logic                         serialActive;
  } smise_state_t;

endpackage : smise_pkg

// >>> smise_event_sync.sv
// Purpose: Two-stage synchroniser and rising-edge detector for event inputs
// Assumes: Inputs are asynchronous to ref_clk
// Notes:   Edge pulse is derived from the second stage only
`timescale 1ns/1ps
module smise_event_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] eventIn,
  output logic      [WIDTH-1:0] eventPulse
);

  typedef struct packed {
    logic [WIDTH-1:0] stageOne;
    logic [WIDTH-1:0] stageTwo;
    logic [WIDTH-1:0] lastLevel;
    logic [WIDTH-1:0] pulse;
  } smise_sync_state_t;

  smise_sync_state_t syncReg;
  smise_sync_state_t syncNext;

  always_comb begin
    syncNext           = syncReg;
    syncNext.stageOne  = eventIn;
    syncNext.stageTwo  = syncReg.stageOne;
    syncNext.lastLevel = syncReg.stageTwo;
    syncNext.pulse     = syncReg.stageTwo & ~syncReg.lastLevel;
  end

  always_ff @(posedge ref_clk) begin
    if (rst) begin
      syncReg <= '0;
    end else begin
      syncReg <= syncNext;
    end
  end

  assign eventPulse = syncReg.pulse;

endmodule : smise_event_sync

// >>> smise_enable_bank.sv
// Purpose: Management interrupt source enable bank with sticky status and routing
// Assumes: AXI4-Lite slave, one outstanding write and one outstanding read
// Notes:   Event pins are synchronised, rising edges set status bits
`timescale 1ns/1ps
module smise_enable_bank
  import smise_pkg::*;
(
  input  wire logic                            ref_clk,
  input  wire logic                            rst,
  // AXI4-Lite write address
  input  wire logic                            s_axi_awvalid,
  output logic                                 s_axi_awready,
  input  wire logic [smise_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]                      s_axi_awprot,
  // AXI4-Lite write data
  input  wire logic                            s_axi_wvalid,
  output logic                                 s_axi_wready,
  input  wire logic [smise_pkg::AXI_DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]                      s_axi_wstrb,
  // AXI4-Lite write response
  output logic                                 s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  output logic [1:0]                           s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic                            s_axi_arvalid,
  output logic                                 s_axi_arready,
  input  wire logic [smise_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]                      s_axi_arprot,
  // AXI4-Lite read data
  output logic                                 s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  output logic [smise_pkg::AXI_DATA_W-1:0]     s_axi_rdata,
  output logic [1:0]                           s_axi_rresp,
  // Event sources, bank three
  input  wire logic                            gpio_pin_twenty,
  input  wire logic                            gpio_pin_twenty_one,
  input  wire logic                            gpio_pin_twenty_two,
  input  wire logic                            gpio_pin_sixty,
  input  wire logic                            gpio_pin_twenty_four,
  input  wire logic                            gpio_pin_twenty_five,
  input  wire logic                            gpio_pin_twenty_six,
  input  wire logic                            gpio_pin_twenty_seven,
  // Event sources, bank four
  input  wire logic                            gpio_pin_thirty,
  input  wire logic                            gpio_pin_thirty_one,
  input  wire logic                            gpio_pin_thirty_two,
  input  wire logic                            gpio_pin_thirty_three,
  input  wire logic                            gpio_pin_forty_one,
  input  wire logic                            fan_speed_sense_event,
  input  wire logic                            gpio_pin_forty_three,
  input  wire logic                            gpio_pin_sixty_one,
  // Event sources, bank five
  input  wire logic                            gpio_pin_fifty,
  input  wire logic                            gpio_pin_fifty_one,
  input  wire logic                            gpio_pin_fifty_two,
  input  wire logic                            gpio_pin_fifty_three,
  input  wire logic                            gpio_pin_fifty_four,
  input  wire logic                            gpio_pin_fifty_five,
  input  wire logic                            gpio_pin_fifty_six,
  input  wire logic                            gpio_pin_fifty_seven,
  // Interrupt outputs
  output logic                                 group_mgmt_irq_n,
  output logic                                 mgmt_irq_pin_n,
  output logic                                 serialIrqReq
);

  // ************************************************************
  // Helper functions
  // ************************************************************
  function automatic logic [2:0] decodeAddr(input logic [AXI_ADDR_W-1:0] addr);
    logic [2:0] sel;
    sel = SEL_NONE;
    case (addr)
      ADDR_STS_THREE: sel = SEL_STS_THREE;
      ADDR_STS_FOUR:  sel = SEL_STS_FOUR;
      ADDR_STS_FIVE:  sel = SEL_STS_FIVE;
      ADDR_EN_THREE:  sel = SEL_EN_THREE;
      ADDR_EN_FOUR:   sel = SEL_EN_FOUR;
      ADDR_EN_FIVE:   sel = SEL_EN_FIVE;
      ADDR_ROUTE:     sel = SEL_ROUTE;
      default:        sel = SEL_NONE;
    endcase
    return sel;
  endfunction : decodeAddr

  function automatic logic [BANK_W-1:0] readByte(
    input logic [2:0]                       sel,
    input logic [NUM_BANKS-1:0][BANK_W-1:0] sts,
    input logic [NUM_BANKS-1:0][BANK_W-1:0] en,
    input logic                             routePin,
    input logic                             routeSerial
  );
    logic [BANK_W-1:0] value;
    value = '0;
    case (sel)
      SEL_STS_THREE: value = sts[0];
      SEL_STS_FOUR:  value = sts[1];
      SEL_STS_FIVE:  value = sts[2];
      SEL_EN_THREE:  value = en[0];
      SEL_EN_FOUR:   value = en[1];
      SEL_EN_FIVE:   value = en[2];
      SEL_ROUTE: begin
        value[ROUTE_PIN_BIT]    = routePin;
        value[ROUTE_SERIAL_BIT] = routeSerial;
      end
      default:       value = '0;
    endcase
    return value;
  endfunction : readByte

  // ************************************************************
  // Event synchronisation
  // ************************************************************
  logic [EVENT_W-1:0] eventRaw;
  logic [EVENT_W-1:0] eventPulse;

  assign eventRaw[7:0] = {gpio_pin_twenty_seven, gpio_pin_twenty_six,
                          gpio_pin_twenty_five, gpio_pin_twenty_four,
                          gpio_pin_sixty, gpio_pin_twenty_two,
                          gpio_pin_twenty_one, gpio_pin_twenty};
  assign eventRaw[15:8] = {gpio_pin_sixty_one, gpio_pin_forty_three,
                           fan_speed_sense_event, gpio_pin_forty_one,
                           gpio_pin_thirty_three, gpio_pin_thirty_two,
                           gpio_pin_thirty_one, gpio_pin_thirty};
  assign eventRaw[23:16] = {gpio_pin_fifty_seven, gpio_pin_fifty_six,
                            gpio_pin_fifty_five, gpio_pin_fifty_four,
                            gpio_pin_fifty_three, gpio_pin_fifty_two,
                            gpio_pin_fifty_one, gpio_pin_fifty};

  smise_event_sync #(
    .WIDTH      (EVENT_W)
  ) u_event_sync (
    .ref_clk    (ref_clk),
    .rst        (rst),
    .eventIn    (eventRaw),
    .eventPulse (eventPulse)
  );

  // ************************************************************
  // State
  // ************************************************************
  smise_state_t stateReg;
  smise_state_t stateNext;

  logic awTake;
  logic wTake;
  logic arTake;

  assign s_axi_awready = (stateReg.wrState == WR_COLLECT) && !stateReg.awHeld;
  assign s_axi_wready  = (stateReg.wrState == WR_COLLECT) && !stateReg.wHeld;
  assign s_axi_arready = (stateReg.rdState == RD_IDLE);
  assign awTake        = s_axi_awvalid && s_axi_awready;
  assign wTake         = s_axi_wvalid && s_axi_wready;
  assign arTake        = s_axi_arvalid && s_axi_arready;

  // ************************************************************
  // Next-state logic
  // ************************************************************
  always_comb begin
    logic [NUM_BANKS-1:0][BANK_W-1:0] clearMask;
    logic [2:0]                       wrSel;
    logic                             pending;
    clearMask = '0;
    wrSel     = decodeAddr(stateReg.awAddr);
    pending   = 1'b0;
    stateNext = stateReg;

    // Write channel capture, either order
    if (awTake) begin
      stateNext.awHeld = 1'b1;
      stateNext.awAddr = s_axi_awaddr;
    end
    if (wTake) begin
      stateNext.wHeld  = 1'b1;
      stateNext.wByte  = s_axi_wdata[BANK_W-1:0];
      stateNext.wLane0 = s_axi_wstrb[0];
    end

    case (stateReg.wrState)
      WR_COLLECT: begin
        if (stateReg.awHeld && stateReg.wHeld) begin
          stateNext.awHeld  = 1'b0;
          stateNext.wHeld   = 1'b0;
          stateNext.wrState = WR_RESP;
          stateNext.bresp   = (wrSel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
          if (stateReg.wLane0) begin
            case (wrSel)
              SEL_STS_THREE: clearMask[0] = stateReg.wByte;
              SEL_STS_FOUR:  clearMask[1] = stateReg.wByte;
              SEL_STS_FIVE:  clearMask[2] = stateReg.wByte;
              SEL_EN_THREE:  stateNext.en[0] = stateReg.wByte;
              SEL_EN_FOUR:   stateNext.en[1] = stateReg.wByte;
              SEL_EN_FIVE:   stateNext.en[2] = stateReg.wByte;
              SEL_ROUTE: begin
                stateNext.routePin    = stateReg.wByte[ROUTE_PIN_BIT];
                stateNext.routeSerial = stateReg.wByte[ROUTE_SERIAL_BIT];
              end
              default: clearMask = '0;
            endcase
          end
        end
      end
      WR_RESP: begin
        if (s_axi_bready) begin
          stateNext.wrState = WR_COLLECT;
        end
      end
      default: stateNext.wrState = WR_COLLECT;
    endcase

    // Read channel
    case (stateReg.rdState)
      RD_IDLE: begin
        if (arTake) begin
          stateNext.rdState = RD_RESP;
          stateNext.rdata   = '0;
          stateNext.rdata[BANK_W-1:0] = readByte(decodeAddr(s_axi_araddr),
                                                 stateReg.sts, stateReg.en,
                                                 stateReg.routePin,
                                                 stateReg.routeSerial);
          stateNext.rresp   = (decodeAddr(s_axi_araddr) == SEL_NONE) ?
                              RESP_SLVERR : RESP_OKAY;
        end
      end
      RD_RESP: begin
        if (s_axi_rready) begin
          stateNext.rdState = RD_IDLE;
        end
      end
      default: stateNext.rdState = RD_IDLE;
    endcase

    // Sticky status, a new event wins over a clear
    for (int b = 0; b < NUM_BANKS; b++) begin
      stateNext.sts[b] = (stateReg.sts[b] & ~clearMask[b])
                       | eventPulse[b*BANK_W +: BANK_W];
    end

    // Group output from status and enable pairs
    for (int b = 0; b < NUM_BANKS; b++) begin
      pending = pending | (|(stateReg.sts[b] & stateReg.en[b]));
    end
    stateNext.groupActive  = pending;
    stateNext.pinActive    = pending && stateReg.routePin;
    stateNext.serialActive = pending && stateReg.routeSerial;
  end

  // ************************************************************
  // State register
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      stateReg              <= '0;
      stateReg.wrState      <= WR_COLLECT;
      stateReg.rdState      <= RD_IDLE;
      stateReg.bresp        <= RESP_OKAY;
      stateReg.rresp        <= RESP_OKAY;
      stateReg.sts          <= {NUM_BANKS{STS_RESET}};
      stateReg.en           <= {NUM_BANKS{EN_RESET}};
      stateReg.routePin     <= ROUTE_RESET;
      stateReg.routeSerial  <= ROUTE_RESET;
    end else begin
      stateReg <= stateNext;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  assign s_axi_bvalid     = (stateReg.wrState == WR_RESP);
  assign s_axi_bresp      = stateReg.bresp;
  assign s_axi_rvalid     = (stateReg.rdState == RD_RESP);
  assign s_axi_rdata      = stateReg.rdata;
  assign s_axi_rresp      = stateReg.rresp;
  assign group_mgmt_irq_n = ~stateReg.groupActive;
  assign mgmt_irq_pin_n   = ~stateReg.pinActive;
  assign serialIrqReq     = stateReg.serialActive;

endmodule : smise_enable_bank

// >>> smise_chk.sv
// Purpose: Port-level checks of the interrupt source enable bank
// Assumes: One clock, synchronous active-high reset
// Notes:   Bound to the top module, watches its ports only
`timescale 1ns/1ps
module smise_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        group_mgmt_irq_n,
  input wire logic        mgmt_irq_pin_n,
  input wire logic        serialIrqReq
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (rst);
  // ************************************************************
  // Bus and interrupt properties
  // ************************************************************
  a_pin_needs_group: assert property (
    !mgmt_irq_pin_n |-> !group_mgmt_irq_n || !$past(group_mgmt_irq_n))
    else $error("pin request without group request");
  a_serial_needs_group: assert property (
    serialIrqReq |-> !group_mgmt_irq_n || !$past(group_mgmt_irq_n))
    else $error("serial request without group request");
  a_release_by_write: assert property (
    $rose(group_mgmt_irq_n) |-> $past(s_axi_bvalid))
    else $error("group request released without a register write");
  a_wr_answer: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read response late");
  a_b_stands: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_r_stands: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read response dropped");
  a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address accepted during response");
  a_rdata_upper: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data upper bits set");
  a_reset_idle: assert property (disable iff (1'b0) rst |=>
    group_mgmt_irq_n && mgmt_irq_pin_n && !serialIrqReq && !s_axi_bvalid && !s_axi_rvalid)
    else $error("outputs not idle after reset");
endmodule : smise_chk

bind smise_enable_bank smise_chk i_chk (
  .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .group_mgmt_irq_n, .mgmt_irq_pin_n,
  .serialIrqReq
);

// >>> smise_host_model.sv
// Purpose: Host side receiver of the routed management interrupt
// Assumes: Pin request active low, serial request active high
// Notes:   Sticky flags, cleared by the bench
`timescale 1ns/1ps
module smise_host_model (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic mgmt_irq_pin_n,
  input  wire logic serialIrqReq,
  input  wire logic clrSeen,
  output logic      pinSeen,
  output logic      serialSeen
);
  // ************************************************************
  // Request capture
  // ************************************************************
  always_ff @(posedge ref_clk) begin
    if (rst || clrSeen) begin
      pinSeen    <= 1'b0;
      serialSeen <= 1'b0;
    end else begin
      if (!mgmt_irq_pin_n) pinSeen <= 1'b1;
      if (serialIrqReq) serialSeen <= 1'b1;
    end
  end
endmodule : smise_host_model

// >>> smise_tb.sv
// Purpose: Self-checking bench of the interrupt source enable bank
// Assumes: AXI4-Lite master driven on rising edges
// Notes:   Reset values first, then register table, source mapping and special cases
`timescale 1ns/1ps
module tb;
  import smise_pkg::*;
  logic ref_clk, rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ea, sa;
  logic [31:0] s_axi_wdata, s_axi_rdata, m, d;
  logic [3:0] s_axi_wstrb;
  logic [2:0] s_axi_awprot, s_axi_arprot;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic [23:0] ev;
  logic group_mgmt_irq_n, mgmt_irq_pin_n, serialIrqReq, clrSeen, pinSeen, serialSeen;
  int fails, checks;
  typedef struct {logic [7:0] a; logic [31:0] d; logic [3:0] s; logic [7:0] q; logic [1:0] r;}
    smise_row_t;
  smise_row_t rows [7] = '{
    '{ADDR_EN_THREE, 32'h000000A5, 4'hF, 8'hA5, RESP_OKAY},
    '{ADDR_EN_FOUR, 32'h0000005A, 4'hF, 8'h5A, RESP_OKAY},
    '{ADDR_EN_FIVE, 32'h000000FF, 4'hF, 8'hFF, RESP_OKAY},
    '{ADDR_EN_FIVE, 32'h00000000, 4'hE, 8'hFF, RESP_OKAY},
    '{ADDR_EN_THREE, 32'hFFFFFF3C, 4'hF, 8'h3C, RESP_OKAY},
    '{ADDR_ROUTE, 32'h000000FF, 4'hF, 8'hC0, RESP_OKAY},
    '{8'h04, 32'h00000012, 4'hF, 8'h00, RESP_SLVERR}};

  smise_enable_bank i_dut (
    .ref_clk, .rst, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_arprot,
    .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp,
    .gpio_pin_twenty(ev[0]), .gpio_pin_twenty_one(ev[1]), .gpio_pin_twenty_two(ev[2]),
    .gpio_pin_sixty(ev[3]), .gpio_pin_twenty_four(ev[4]), .gpio_pin_twenty_five(ev[5]),
    .gpio_pin_twenty_six(ev[6]), .gpio_pin_twenty_seven(ev[7]), .gpio_pin_thirty(ev[8]),
    .gpio_pin_thirty_one(ev[9]), .gpio_pin_thirty_two(ev[10]),
    .gpio_pin_thirty_three(ev[11]), .gpio_pin_forty_one(ev[12]),
    .fan_speed_sense_event(ev[13]), .gpio_pin_forty_three(ev[14]),
    .gpio_pin_sixty_one(ev[15]), .gpio_pin_fifty(ev[16]), .gpio_pin_fifty_one(ev[17]),
    .gpio_pin_fifty_two(ev[18]), .gpio_pin_fifty_three(ev[19]),
    .gpio_pin_fifty_four(ev[20]), .gpio_pin_fifty_five(ev[21]),
    .gpio_pin_fifty_six(ev[22]), .gpio_pin_fifty_seven(ev[23]),
    .group_mgmt_irq_n, .mgmt_irq_pin_n, .serialIrqReq);

  smise_host_model i_host (.ref_clk, .rst, .mgmt_irq_pin_n, .serialIrqReq, .clrSeen,
    .pinSeen, .serialSeen);

  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic tally_and_finish();
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic axi_write(input logic [7:0] a, input logic [31:0] dv, input logic [3:0] s);
    logic aw, w;
    int n;
    aw = 1'b1;
    w = 1'b1;
    n = 0;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= dv;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end while (!(s_axi_bvalid && !aw && !w) && n < 50);
    if (n >= 50) fails++;
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    logic ar;
    int n;
    ar = 1'b1;
    n = 0;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end while (!(s_axi_rvalid && !ar) && n < 50);
    if (n >= 50) fails++;
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : axi_read

  task automatic pulse(input int i);
    @(posedge ref_clk);
    ev[i] <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ev[i] <= 1'b0;
  endtask : pulse

  task automatic wait_irq(input logic v);
    int n;
    n = 0;
    while (group_mgmt_irq_n !== v && n < 20) begin
      @(posedge ref_clk);
      n++;
    end
  endtask : wait_irq

  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    fails++;
    tally_and_finish();
  end

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {s_axi_awprot, s_axi_arprot, ev, clrSeen} = 31'h0;
    rst = 1'b1;
    repeat (8) @(posedge ref_clk);
    rst <= 1'b0;
    for (int k = 0; k < 4; k++) begin
      axi_read(k == 3 ? ADDR_ROUTE : ADDR_EN_THREE + 8'(4 * k));
      chk(d, 32'h0);
    end
    foreach (rows[k]) begin
      axi_write(rows[k].a, rows[k].d, rows[k].s);
      chk(r, rows[k].r);
      axi_read(rows[k].a);
      chk(d, {24'h000000, rows[k].q});
      chk({30'h0, r}, {30'h0, rows[k].r});
    end
    for (int i = 0; i < 24; i++) begin
      ea = ADDR_EN_THREE + 8'(4 * (i / 8));
      sa = ADDR_STS_THREE + 8'(4 * (i / 8));
      m = 32'h1 << (i % 8);
      axi_write(ea, m, 4'hF);
      pulse(i);
      wait_irq(1'b0);
      chk(group_mgmt_irq_n, 32'h0);
      chk({mgmt_irq_pin_n, serialIrqReq}, 32'h1);
      axi_read(sa);
      chk(d, m);
      axi_write(sa, m, 4'hF);
      wait_irq(1'b1);
      chk(group_mgmt_irq_n, 32'h1);
      axi_read(sa);
      chk(d, 32'h0);
    end
    axi_write(ADDR_EN_FOUR, 32'h0, 4'hF);
    pulse(13);
    repeat (10) @(posedge ref_clk);
    chk(group_mgmt_irq_n, 32'h1);
    axi_read(ADDR_STS_FOUR);
    chk(d, 32'h20);
    axi_write(ADDR_EN_FOUR, 32'h20, 4'hF);
    wait_irq(1'b0);
    @(posedge ref_clk);
    chk({group_mgmt_irq_n, pinSeen, serialSeen}, 32'h3);
    axi_write(ADDR_ROUTE, 32'h0, 4'hF);
    @(posedge ref_clk);
    clrSeen <= 1'b1;
    @(posedge ref_clk);
    clrSeen <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk({group_mgmt_irq_n, mgmt_irq_pin_n, serialIrqReq, pinSeen, serialSeen}, 32'h8);
    axi_write(ADDR_STS_FOUR, 32'h20, 4'hF);
    wait_irq(1'b1);
    chk(group_mgmt_irq_n, 32'h1);
    axi_write(ADDR_EN_FIVE, 32'h81, 4'hF);
    @(posedge ref_clk);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    axi_read(ADDR_EN_FIVE);
    chk(d, 32'h0);
    tally_and_finish();
  end
endmodule : tb
